// [src/ckc_pkg.sv]
// Shared constants and types of the system clock controller and its partner.
package ckc_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CKC_HF   = 2'b00,
    CKC_ULP  = 2'b01,
    CKC_XTAL = 2'b10,
    CKC_EXT  = 2'b11
  } ckc_src_t;

  typedef enum logic [1:0] {
    CKC_ACTIVE  = 2'b00,
    CKC_IDLE    = 2'b01,
    CKC_STANDBY = 2'b10,
    CKC_PDOWN   = 2'b11
  } ckc_mode_t;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] CKC_A_MAIN_SEL  = 6'h00;
  localparam logic [5:0] CKC_A_MAIN_DIV  = 6'h01;
  localparam logic [5:0] CKC_A_MAIN_LOCK = 6'h02;
  localparam logic [5:0] CKC_A_MAIN_STAT = 6'h03;
  localparam logic [5:0] CKC_A_HF_CTRL   = 6'h10;
  localparam logic [5:0] CKC_A_HF_TRIM_A = 6'h11;
  localparam logic [5:0] CKC_A_HF_TRIM_B = 6'h12;
  localparam logic [5:0] CKC_A_ULP_CTRL  = 6'h18;
  localparam logic [5:0] CKC_A_XTAL_CTRL = 6'h1C;
  localparam logic [5:0] CKC_A_ERR_BASE  = 6'h20;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CKC_B_RSB     = 1;
  localparam int CKC_B_XEN     = 0;
  localparam int CKC_B_XSEL    = 2;
  localparam int CKC_B_XSUT    = 4;
  localparam int CKC_B_PEN     = 0;
  localparam int CKC_B_PDIV    = 1;
  localparam int CKC_B_LOCK    = 0;
  localparam logic [3:0] CKC_R_PDIV = 4'h8;
  localparam logic       CKC_R_PEN  = 1'b1;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam logic [2:0]  CKC_KEY_WINDOW = 3'h4;
  localparam logic [15:0] CKC_EXT_SUT    = 16'h0002;
  localparam logic [15:0] CKC_ULP_EXTRA  = 16'h0004;
  localparam logic [15:0] CKC_XSUT_0     = 16'h0100;
  localparam logic [15:0] CKC_XSUT_1     = 16'h0400;
  localparam logic [15:0] CKC_XSUT_2     = 16'h1000;
  localparam logic [15:0] CKC_XSUT_3     = 16'h4000;
  localparam logic [4:0]  CKC_ULP_DIV_M1 = 5'h1F;
  localparam logic [15:0] CKC_BAUD_MIN   = 16'h004A;
  localparam int          CKC_ERR_SHIFT  = 10;

endpackage

// [src/ckc_if.sv]
// Interface joining the clock controller and its partner.
`timescale 1ns/100ps
`default_nettype none
interface ckc_if;
  import ckc_pkg::*;

  // Register port.
  logic [5:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic       key;
  logic [7:0] rdata;
  // Requests and sleep state from the partner.
  logic [3:0] per_req;
  logic       main_req;
  ckc_mode_t  mode;
  logic       nvm_busy;
  // Clocks handed out as a run level and one-cycle enables.
  logic       main_run;
  logic       per_tick;
  logic       ulp_1k_tick;

  modport dev (
    input  addr, wdata, wr, rd, key, per_req, main_req, mode, nvm_busy,
    output rdata, main_run, per_tick, ulp_1k_tick
  );
  modport host (
    output addr, wdata, wr, rd, key, per_req, main_req, mode, nvm_busy,
    input  rdata, main_run, per_tick, ulp_1k_tick
  );
endinterface
`default_nettype wire

// [src/ckc_startup.sv]
// Start-up counter that marks an oscillator stable after enough ticks.
`timescale 1ns/100ps
`default_nettype none
module ckc_startup #(
  parameter int W = 16
) (
  // Clock and reset.
  input  wire logic         mclk_i,
  input  wire logic         rst_b_i,
  // Oscillator side.
  input  wire logic         en_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] limit_i,
  // Result.
  output logic              ready_o
);

  logic [W-1:0] cnt_q;

  // Count ticks while enabled; dropping the enable restarts the count.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q   <= '0;
      ready_o <= 1'b0;
    end else if (!en_i) begin
      cnt_q   <= '0;
      ready_o <= 1'b0;
    end else if (tick_i && !ready_o) begin
      cnt_q   <= cnt_q + 1'b1;
      ready_o <= (cnt_q + 1'b1) >= limit_i;
    end
  end

endmodule
`default_nettype wire

// [src/ckc_ctrl.sv]
// Clock controller: source select, prescaler, gating, trim and lock.
//
// Summary of operation
// - Stop sources neither used nor requested.
// - Standby-run bit keeps oscillator running except power-down.
// - Main clock runs in active/idle; standby on demand.
// - Power-down waits for memory operations before stopping.
// - Switch completes after start-up edges; pending blocks new selects.
// - Report switching flag and per-source stable status.
// - Partner never alters the crystal while it is the selected source; partner checks only the last select value it sent.
// - Peripheral clock is main clock divided 1 to 64.
// - Select and prescaler change only via protected write.
// - Reset selects high-frequency oscillator, divide by six.
// - Oscillator frequency taken from the fuse field.
// - Internal oscillators enable on peripheral request.
// - Crystal needs enable bit; enable overrides its pins.
// - Oscillator trims loaded from fuses at reset.
// - Trim writes refused by lock fuse, or by lock bit while high-frequency oscillator is selected.
// - Stored errors held as signed compressed bytes.
// - Partner compensates baud, target at least 0x4A.
// - Low-power oscillator gives a 1.024 kHz tick.
// - Low-power oscillator ready after start-up plus four.
// - Partner picks crystal or clock input and start-up.
// - Clock input on crystal pin uses two-cycle start-up.
// - External pin configured on request; two-cycle start-up.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
module ckc_ctrl
  import ckc_pkg::*;
#(
  parameter logic [15:0] HF_SUT  = 16'h0040,
  parameter logic [15:0] ULP_SUT = 16'h0020
) (
  // Clock and reset.
  input  wire logic              mclk_i,
  input  wire logic              rst_b_i,
  // Partner side.
  ckc_if.dev                     bus,
  // Oscillator ticks, one per source, synchronous to mclk_i.
  input  wire logic [3:0]        osc_tick_i,
  // Fuses.
  input  wire logic [1:0]        fuse_freq_sel_i,
  input  wire logic              fuse_cal_lock_i,
  input  wire logic              fuse_lock_en_i,
  input  wire logic [6:0]        fuse_cal_i,
  input  wire logic [3:0]        fuse_tmp_i,
  input  wire logic [3:0][7:0]   fuse_err_i,
  // Oscillator and pin control.
  output logic [3:0]             osc_en_o,
  output logic [1:0]             hf_freq_sel_o,
  output logic [6:0]             hf_cal_o,
  output logic [3:0]             hf_tmp_o,
  output logic                   xtal_pin_ovr_o,
  output logic                   xtal_ext_o,
  output logic                   ext_pin_cfg_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] div_of(input logic pen,
                                        input logic [3:0] pdiv);
    if (!pen) return 7'h01;
    unique case (pdiv)
      4'h0: return 7'h02;
      4'h1: return 7'h04;
      4'h2: return 7'h08;
      4'h3: return 7'h10;
      4'h4: return 7'h20;
      4'h5: return 7'h40;
      4'h8: return 7'h06;
      4'h9: return 7'h0A;
      4'hA: return 7'h0C;
      4'hB: return 7'h18;
      4'hC: return 7'h30;
      default: return 7'h01; // Reserved codes pass the clock through.
    endcase
  endfunction

  function automatic logic [15:0] sut_of(input logic [1:0] c);
    unique case (c)
      2'h0: return CKC_XSUT_0;
      2'h1: return CKC_XSUT_1;
      2'h2: return CKC_XSUT_2;
      2'h3: return CKC_XSUT_3;
    endcase
  endfunction

  function automatic logic is_prot(input logic [5:0] a);
    return a == CKC_A_MAIN_SEL || a == CKC_A_MAIN_DIV ||
           a == CKC_A_MAIN_LOCK || a == CKC_A_HF_CTRL ||
           a == CKC_A_HF_TRIM_A || a == CKC_A_HF_TRIM_B ||
           a == CKC_A_ULP_CTRL || a == CKC_A_XTAL_CTRL;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ckc_src_t          sel_q;
  ckc_src_t          tgt_q;
  logic              pend_q;
  logic              lock_q;
  logic              init_q;
  logic              pen_q;
  logic [3:0]        pdiv_q;
  logic              hf_rsb_q;
  logic              ulp_rsb_q;
  logic              x_en_q;
  logic              x_rsb_q;
  logic              x_ext_q;
  logic [1:0]        x_sut_q;
  logic signed [7:0] err_q [4];
  logic [2:0]        win_q;
  logic              main_run_q, per_tick_q, ulp_tick_q;
  logic [5:0]        pc_q;
  logic [4:0]        uc_q;
  logic [7:0]        rdata_q;
  logic [3:0]        used, rsb, en_d;
  logic [3:0]        ready;
  logic [3:0]        stat;
  logic [15:0]       lim [4];
  logic              prot_ok, wr_p, cal_ok;
  logic [6:0]        div;
  logic              main_tick;

  assign prot_ok = win_q != 3'h0;
  assign wr_p    = bus.wr && prot_ok && is_prot(bus.addr);
  assign cal_ok  = !fuse_cal_lock_i && !(sel_q == CKC_HF && lock_q);
  assign div     = div_of(pen_q, pdiv_q);
  assign main_tick = osc_tick_i[sel_q] && main_run_q;

  assign bus.rdata       = rdata_q;
  assign bus.main_run    = main_run_q;
  assign bus.per_tick    = per_tick_q;
  assign bus.ulp_1k_tick = ulp_tick_q;

  // ----------------------------------------------------------------
  // Source demand and start-up
  // ----------------------------------------------------------------
  // A source, the crystal only while enabled, runs while it feeds the main clock,
  // is the switch target, is requested, or is held by its standby-run bit outside power-down.
  always_comb begin
    rsb = {1'b0, x_rsb_q, ulp_rsb_q, hf_rsb_q};
    for (int s = 0; s < 4; s++) begin
      used[s] = main_run_q && (sel_q == 2'(s) || (pend_q && tgt_q == 2'(s)));
      en_d[s] = used[s] || bus.per_req[s] ||
                (rsb[s] && bus.mode != CKC_PDOWN);
      stat[s] = ready[s] && (used[s] || bus.per_req[s]);
    end
    en_d[2] = en_d[2] && x_en_q;
    lim[0] = HF_SUT;
    lim[1] = ULP_SUT + CKC_ULP_EXTRA;
    lim[2] = x_ext_q ? CKC_EXT_SUT : sut_of(x_sut_q);
    lim[3] = CKC_EXT_SUT;
  end

  for (genvar g = 0; g < 4; g++) begin : g_su
    ckc_startup #(.W(16)) u_su (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_b_i),
      .en_i    (osc_en_o[g]),
      .tick_i  (osc_tick_i[g]),
      .limit_i (lim[g]),
      .ready_o (ready[g])
    );
  end

  // Oscillator enables and pin overrides.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_en_o       <= 4'h1;
      xtal_pin_ovr_o <= 1'b0;
      xtal_ext_o     <= 1'b0;
      ext_pin_cfg_o  <= 1'b0;
    end else begin
      osc_en_o       <= en_d;
      xtal_pin_ovr_o <= x_en_q;
      xtal_ext_o     <= x_ext_q;
      ext_pin_cfg_o  <= en_d[3];
    end
  end

  // ----------------------------------------------------------------
  // Main clock gating and prescaler
  // ----------------------------------------------------------------
  // Once stopped in power-down the clock stays off until the mode leaves
  // it, so a late memory request cannot restart it behind sleep's back.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      main_run_q <= 1'b1;
    end else begin
      unique case (bus.mode)
        CKC_ACTIVE, CKC_IDLE: main_run_q <= 1'b1;
        CKC_STANDBY: main_run_q <= bus.main_req || rsb[sel_q];
        CKC_PDOWN:   main_run_q <= main_run_q && bus.nvm_busy;
      endcase
    end
  end

  // Division counter; a smaller new factor wraps at once.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pc_q       <= 6'h00;
      per_tick_q <= 1'b0;
    end else if (main_tick && {1'b0, pc_q} >= div - 7'h01) begin
      pc_q       <= 6'h00;
      per_tick_q <= 1'b1;
    end else begin
      pc_q       <= main_tick ? pc_q + 6'h01 : pc_q;
      per_tick_q <= 1'b0;
    end
  end

  // Low-power oscillator divided by 32 for timers and supervisors.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      uc_q       <= 5'h00;
      ulp_tick_q <= 1'b0;
    end else begin
      ulp_tick_q <= 1'b0;
      if (osc_tick_i[1] && ready[1]) begin
        uc_q       <= uc_q + 5'h01;
        ulp_tick_q <= uc_q == CKC_ULP_DIV_M1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Protection window
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      win_q <= 3'h0;
    end else if (bus.key) begin
      win_q <= CKC_KEY_WINDOW;
    end else if (wr_p) begin
      win_q <= 3'h0;
    end else if (prot_ok) begin
      win_q <= win_q - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Source select, prescaler and lock
  // ----------------------------------------------------------------
  // A pending switch is never abandoned: a dead external clock is only
  // left through a system reset, so select writes are refused meanwhile.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_q  <= CKC_HF;
      tgt_q  <= CKC_HF;
      pend_q <= 1'b0;
      pen_q  <= CKC_R_PEN;
      pdiv_q <= CKC_R_PDIV;
      lock_q <= 1'b0;
      init_q <= 1'b0;
    end else begin
      init_q <= 1'b1;
      if (!init_q) lock_q <= fuse_lock_en_i;
      if (pend_q && ready[tgt_q]) begin
        sel_q  <= tgt_q;
        pend_q <= 1'b0;
      end
      if (wr_p && !lock_q && !pend_q && bus.addr == CKC_A_MAIN_SEL &&
          bus.wdata[1:0] != sel_q) begin
        tgt_q  <= ckc_src_t'(bus.wdata[1:0]);
        pend_q <= 1'b1;
      end
      if (wr_p && !lock_q && bus.addr == CKC_A_MAIN_DIV) begin
        pen_q  <= bus.wdata[CKC_B_PEN];
        pdiv_q <= bus.wdata[CKC_B_PDIV+:4];
      end
      if (wr_p && !lock_q && bus.addr == CKC_A_MAIN_LOCK)
        lock_q <= bus.wdata[CKC_B_LOCK];
    end
  end

  // ----------------------------------------------------------------
  // Oscillator control, trims and stored errors
  // ----------------------------------------------------------------
  // Fuse values are caught in the first cycle after reset release.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hf_freq_sel_o <= 2'h0;
      hf_cal_o      <= 7'h00;
      hf_tmp_o      <= 4'h0;
      for (int i = 0; i < 4; i++) err_q[i] <= 8'sh00;
    end else if (!init_q) begin
      hf_freq_sel_o <= fuse_freq_sel_i;
      hf_cal_o      <= fuse_cal_i;
      hf_tmp_o      <= fuse_tmp_i;
      for (int i = 0; i < 4; i++) err_q[i] <= signed'(fuse_err_i[i]);
    end else if (wr_p && cal_ok) begin
      if (bus.addr == CKC_A_HF_TRIM_A) hf_cal_o <= bus.wdata[6:0];
      if (bus.addr == CKC_A_HF_TRIM_B) hf_tmp_o <= bus.wdata[3:0];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hf_rsb_q  <= 1'b0;
      ulp_rsb_q <= 1'b0;
      x_en_q    <= 1'b0;
      x_rsb_q   <= 1'b0;
      x_ext_q   <= 1'b0;
      x_sut_q   <= 2'h0;
    end else if (wr_p) begin
      if (bus.addr == CKC_A_HF_CTRL)  hf_rsb_q  <= bus.wdata[CKC_B_RSB];
      if (bus.addr == CKC_A_ULP_CTRL) ulp_rsb_q <= bus.wdata[CKC_B_RSB];
      if (bus.addr == CKC_A_XTAL_CTRL) begin
        x_en_q  <= bus.wdata[CKC_B_XEN];
        x_rsb_q <= bus.wdata[CKC_B_RSB];
        x_ext_q <= bus.wdata[CKC_B_XSEL];
        x_sut_q <= bus.wdata[CKC_B_XSUT+:2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        CKC_A_MAIN_SEL:  rdata_q <= {6'h00, sel_q};
        CKC_A_MAIN_DIV:  rdata_q <= {3'h0, pdiv_q, pen_q};
        CKC_A_MAIN_LOCK: rdata_q <= {7'h00, lock_q};
        CKC_A_MAIN_STAT: rdata_q <= {stat, 3'h0, pend_q};
        CKC_A_HF_CTRL:   rdata_q <= {6'h00, hf_rsb_q, 1'b0};
        CKC_A_HF_TRIM_A: rdata_q <= {1'b0, hf_cal_o};
        CKC_A_HF_TRIM_B: rdata_q <= {fuse_cal_lock_i, 3'h0, hf_tmp_o};
        CKC_A_ULP_CTRL:  rdata_q <= {6'h00, ulp_rsb_q, 1'b0};
        CKC_A_XTAL_CTRL:
          rdata_q <= {2'h0, x_sut_q, 1'b0, x_ext_q, x_rsb_q, x_en_q};
        6'h20, 6'h21, 6'h22, 6'h23: rdata_q <= err_q[bus.addr[1:0]];
        default:         rdata_q <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

// [src/ckc_host.sv]
// Partner end: software register master, peripheral requests, baud helper.
`timescale 1ns/100ps
`default_nettype none
module ckc_host
  import ckc_pkg::*;
(
  // Clock and reset.
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // Controller side.
  ckc_if.host              bus,
  // Command port.
  input  wire logic [5:0]  cmd_addr_i,
  input  wire logic [7:0]  cmd_data_i,
  input  wire logic        cmd_wr_i,
  input  wire logic        cmd_rd_i,
  input  wire logic        cmd_prot_i,
  output logic             busy_o,
  output logic [7:0]       rdata_o,
  output logic             rvalid_o,
  // Peripheral requests and sleep.
  input  wire logic [3:0]  per_req_i,
  input  wire logic        main_req_i,
  input  wire ckc_mode_t   mode_i,
  input  wire logic        nvm_busy_i,
  // Baud compensation.
  input  wire logic [15:0] baud_ideal_i,
  input  wire logic [7:0]  baud_err_i,
  output logic [15:0]      baud_o
);

  typedef enum logic {H_IDLE = 1'b0, H_KEY = 1'b1} ckc_hst_t;

  ckc_hst_t   st_q;
  logic       rp_q;
  logic       xen_q;
  logic [1:0] sel_q;
  logic       refuse;

  // Adds target*error/1024 to a target raised to the safe minimum.
  function automatic logic [15:0] comp(input logic [15:0] ideal,
                                       input logic [7:0] err);
    logic signed [31:0] t;
    t = signed'({16'h0000, (ideal < CKC_BAUD_MIN) ? CKC_BAUD_MIN : ideal});
    t = t + ((t * 32'(signed'(err))) >>> CKC_ERR_SHIFT);
    return t[15:0];
  endfunction

  // Never touch the crystal while it is the last source this partner wrote to the select register.
  assign refuse = cmd_addr_i == CKC_A_XTAL_CTRL && sel_q == 2'h2;

  // Protected writes go out as key then write in the next cycle.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q       <= H_IDLE;
      bus.addr   <= 6'h00;
      bus.wdata  <= 8'h00;
      bus.wr     <= 1'b0;
      bus.rd     <= 1'b0;
      bus.key    <= 1'b0;
      busy_o     <= 1'b0;
      xen_q      <= 1'b0;
      sel_q      <= 2'h0;
    end else begin
      bus.wr  <= 1'b0;
      bus.rd  <= 1'b0;
      bus.key <= 1'b0;
      unique case (st_q)
        H_IDLE: begin
          if (cmd_wr_i && !refuse) begin
            bus.addr  <= cmd_addr_i;
            bus.wdata <= cmd_data_i;
            bus.key   <= cmd_prot_i;
            bus.wr    <= !cmd_prot_i;
            busy_o    <= cmd_prot_i;
            st_q      <= cmd_prot_i ? H_KEY : H_IDLE;
            if (cmd_addr_i == CKC_A_XTAL_CTRL) xen_q <= cmd_data_i[CKC_B_XEN];
            if (cmd_addr_i == CKC_A_MAIN_SEL)  sel_q <= cmd_data_i[1:0];
          end else if (cmd_rd_i) begin
            bus.addr <= cmd_addr_i;
            bus.rd   <= 1'b1;
          end
        end
        H_KEY: begin
          bus.wr <= 1'b1;
          busy_o <= 1'b0;
          st_q   <= H_IDLE;
        end
      endcase
    end
  end

  // Read data stands the cycle after the strobe.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rp_q     <= 1'b0;
      rvalid_o <= 1'b0;
      rdata_o  <= 8'h00;
    end else begin
      rp_q     <= bus.rd;
      rvalid_o <= rp_q;
      if (rp_q) rdata_o <= bus.rdata;
    end
  end

  // Requests; the crystal is asked for only once it is enabled.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus.per_req  <= 4'h0;
      bus.main_req <= 1'b0;
      bus.mode     <= CKC_ACTIVE;
      bus.nvm_busy <= 1'b0;
      baud_o       <= 16'h0000;
    end else begin
      bus.per_req  <= per_req_i & {1'b1, xen_q, 2'h3};
      bus.main_req <= main_req_i;
      bus.mode     <= mode_i;
      bus.nvm_busy <= nvm_busy_i;
      baud_o       <= comp(baud_ideal_i, baud_err_i);
    end
  end

endmodule
`default_nettype wire

// [bench/ckc_asserts.sv]
// Concurrent checks on the link between the controller and its partner.
`timescale 1ns/100ps
`default_nettype none
module ckc_asserts
  import ckc_pkg::*;
(
  // Clock and reset.
  input wire logic       mclk_i,
  input wire logic       rst_b_i,
  // Link signals.
  input wire logic       wr,
  input wire logic       rd,
  input wire logic       key,
  input wire logic [7:0] rdata,
  input wire ckc_mode_t  mode,
  input wire logic       nvm_busy,
  input wire logic       main_run,
  input wire logic       per_tick,
  input wire logic       ulp_1k_tick
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  // The unlock strobe must be followed at once by the write.
  sequence s_unlock;
    key ##1 wr;
  endsequence
  sequence s_awake;
    (mode == CKC_ACTIVE || mode == CKC_IDLE)[*2];
  endsequence
  sequence s_enter_pd;
    mode != CKC_PDOWN ##1 (mode == CKC_PDOWN && nvm_busy);
  endsequence

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_key_then_wr: assert property (key |-> s_unlock)
    else $error("unlock not followed by write");
  a_strobe_excl: assert property (!(wr && rd) && !(key && wr))
    else $error("strobes overlap");
  a_rdata_hold: assert property (!rd |=> $stable(rdata))
    else $error("read data moved without a read");
  a_run_awake: assert property (s_awake |-> main_run)
    else $error("main clock stopped while awake");
  a_pd_nvm_wait: assert property (s_enter_pd |=> main_run)
    else $error("main clock stopped before memory idle");
  a_pd_stop: assert property (
    (mode == CKC_PDOWN && !nvm_busy)[*3] |-> !main_run)
    else $error("main clock runs in power-down");
  a_stop_no_tick: assert property (!main_run[*3] |-> !per_tick)
    else $error("peripheral tick with main clock off");
  a_ulp_spacing: assert property (
    ulp_1k_tick |=> !ulp_1k_tick[*8])
    else $error("slow tick too frequent");
endmodule
`default_nettype wire

// [bench/system_clock_controller_tb.sv]
// Self-checking bench: controller and partner joined by their interface.
`timescale 1ns/100ps
`default_nettype none
module system_clock_controller_tb
  import ckc_pkg::*;
;
  logic        mclk_i = 0, rst_b_i = 0, tk = 0, cal_lock = 0, lock_en = 0;
  logic [5:0]  cmd_addr = 0;
  logic [7:0]  cmd_data = 0, rdata_o, baud_err = 0, d;
  logic        cmd_wr = 0, cmd_rd = 0, cmd_prot = 0, rvalid_o;
  logic [3:0]  per_req = 0, osc_en_o;
  logic        main_req = 0, nvm_busy = 0, ext_cfg;
  ckc_mode_t   mode = CKC_ACTIVE;
  logic [15:0] baud_ideal = 0, baud_o;
  logic [1:0]  freq_o;
  int          failures = 0, checked = 0, n, m;

  // Clock, and oscillator ticks on every other cycle.
  always #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i) tk <= ~tk;

  ckc_if i_ckc_if();
  ckc_ctrl #(.HF_SUT(16'h0002), .ULP_SUT(16'h0002)) i_ckc_ctrl (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus(i_ckc_if.dev),
    .osc_tick_i({4{tk}}), .fuse_freq_sel_i(2'h1),
    .fuse_cal_lock_i(cal_lock), .fuse_lock_en_i(lock_en),
    .fuse_cal_i(7'h2A), .fuse_tmp_i(4'h3),
    .fuse_err_i({8'h44, 8'h33, 8'h22, 8'h11}), .osc_en_o(osc_en_o),
    .hf_freq_sel_o(freq_o), .hf_cal_o(), .hf_tmp_o(),
    .xtal_pin_ovr_o(), .xtal_ext_o(), .ext_pin_cfg_o(ext_cfg));
  ckc_host i_ckc_host (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus(i_ckc_if.host),
    .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data), .cmd_wr_i(cmd_wr),
    .cmd_rd_i(cmd_rd), .cmd_prot_i(cmd_prot), .busy_o(),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .per_req_i(per_req),
    .main_req_i(main_req), .mode_i(mode), .nvm_busy_i(nvm_busy),
    .baud_ideal_i(baud_ideal), .baud_err_i(baud_err), .baud_o(baud_o));
  ckc_asserts i_ckc_asserts (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .wr(i_ckc_if.wr),
    .rd(i_ckc_if.rd), .key(i_ckc_if.key), .rdata(i_ckc_if.rdata),
    .mode(i_ckc_if.mode), .nvm_busy(i_ckc_if.nvm_busy),
    .main_run(i_ckc_if.main_run), .per_tick(i_ckc_if.per_tick),
    .ulp_1k_tick(i_ckc_if.ulp_1k_tick));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task reset();
    rst_b_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
  endtask
  // A write leaves room for the unlock cycle before the next command.
  task wr(input logic [5:0] a, input logic [7:0] v, input logic p);
    @(posedge mclk_i);
    {cmd_addr, cmd_data, cmd_prot, cmd_wr} <= {a, v, p, 1'b1};
    @(posedge mclk_i);
    cmd_wr <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask
  task rd(input logic [5:0] a);
    @(posedge mclk_i);
    {cmd_addr, cmd_rd} <= {a, 1'b1};
    @(posedge mclk_i);
    cmd_rd <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    chk(rvalid_o, 1'b1);
    d = rdata_o;
  endtask
  // Counts peripheral and slow ticks over a span of cycles.
  task cnt(input int c);
    n = 0;
    m = 0;
    repeat (c) begin
      @(posedge mclk_i);
      #1;
      if (i_ckc_if.per_tick === 1'b1) n++;
      if (i_ckc_if.ulp_1k_tick === 1'b1) m++;
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset();
    rd(CKC_A_MAIN_DIV); chk(d, 8'h11);
    rd(CKC_A_HF_TRIM_A); chk(d, 8'h2A);
    rd(CKC_A_ERR_BASE); chk(d, 8'h11);
    chk(freq_o, 2'h1);
    $display("reset test done");
  endtask
  // Divide by 64 gives one tick per 128 cycles at this tick rate.
  task t_div();
    wr(CKC_A_MAIN_DIV, 8'h0B, 1'b1);
    cnt(1280); chk(n inside {[9:11]}, 1);
    wr(CKC_A_MAIN_DIV, 8'h00, 1'b0);
    rd(CKC_A_MAIN_DIV); chk(d, 8'h0B);
    wr(CKC_A_MAIN_DIV, 8'h00, 1'b1);
    cnt(128); chk(n inside {[63:65]}, 1);
    $display("prescaler test done");
  endtask
  task t_sleep();
    mode <= CKC_STANDBY;
    repeat (6) @(posedge mclk_i); chk(i_ckc_if.main_run, 0);
    main_req <= 1'b1;
    repeat (6) @(posedge mclk_i); chk(i_ckc_if.main_run, 1);
    main_req <= 1'b0;
    mode     <= CKC_ACTIVE;
    nvm_busy <= 1'b1;
    repeat (4) @(posedge mclk_i);
    mode <= CKC_PDOWN;
    repeat (8) @(posedge mclk_i); chk(i_ckc_if.main_run, 1);
    nvm_busy <= 1'b0;
    repeat (8) @(posedge mclk_i); chk(i_ckc_if.main_run, 0);
    wr(CKC_A_HF_CTRL, 8'h02, 1'b1);
    mode <= CKC_STANDBY;
    repeat (6) @(posedge mclk_i); chk(i_ckc_if.main_run, 1);
    mode <= CKC_ACTIVE;
    repeat (4) @(posedge mclk_i);
    $display("sleep test done");
  endtask
  task t_ulp();
    per_req <= 4'hE;
    cnt(150); chk(16'(m), 16'h0002);
    rd(CKC_A_MAIN_STAT); chk(d & 8'hE1, 8'hA0);
    chk({osc_en_o, ext_cfg}, 5'h17);
    per_req <= 4'h0;
    repeat (8) @(posedge mclk_i); chk({osc_en_o, ext_cfg}, 5'h02);
    $display("request test done");
  endtask
  // Crystal disabled, so the switch stays pending until reset.
  task t_switch();
    wr(CKC_A_MAIN_SEL, 8'h02, 1'b1);
    rd(CKC_A_MAIN_STAT); chk(d & 8'h01, 8'h01);
    chk(osc_en_o[2], 0);
    {baud_ideal, baud_err} <= {16'h0100, 8'hF0};
    repeat (4) @(posedge mclk_i); chk(baud_o, 16'h00FC);
    {baud_ideal, baud_err} <= {16'h0040, 8'h00};
    repeat (4) @(posedge mclk_i); chk(baud_o, 16'h004A);
    $display("switch test done");
  endtask
  task t_trim();
    for (int l = 0; l < 3; l++) begin
      {lock_en, cal_lock} <= l[1:0];
      reset();
      wr(CKC_A_HF_TRIM_A, 8'h05, 1'b1);
      rd(CKC_A_HF_TRIM_A); chk(d, l ? 8'h2A : 8'h05);
    end
    $display("trim test done");
  endtask

  task final_report();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence, and a watchdog well beyond its length.
  initial begin
    reset();
    t_reset(); t_div(); t_sleep(); t_ulp(); t_switch(); t_trim();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    failures++;
    final_report();
  end
endmodule
`default_nettype wire
